// ### idsp_regs.sv
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps

module idsp_regs
    import idsp_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // Avalon-MM slave
    input  wire logic [BUS_ADDR_W-1:0]   address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [BUS_DATA_W-1:0]   writedata,
    input  wire logic [3:0]              byteenable,
    output logic      [BUS_DATA_W-1:0]   readdata,
    output logic                         waitrequest,
    // Signal processor side
    input  wire logic [7:0]              proc_status_view,
    input  wire logic [7:0]              loop_current_in,
    output idsp_proc_t                   proc_out,
    output idsp_load_t                   proc_load,
    // Line interface side
    output idsp_cfg_t                    line_cfg,
    output logic      [7:0]              window_mode_reg
);

    // Index that no register owns; bit 8 set keeps it clear of every real index
    localparam logic [8:0]  NO_INDEX     = 9'h100;
    localparam logic [1:0]  LANE_ALIGNED = 2'b00;

    // Register index from a byte address; misaligned addresses map nowhere
    function automatic logic [8:0] reg_index(input logic [BUS_ADDR_W-1:0] a);
        logic [8:0] r;
        r = NO_INDEX;
        if (a[1:0] == LANE_ALIGNED)
        begin
            r = {1'b0, a[BUS_ADDR_W-1:2]};
        end
        return r;
    endfunction

    // True when the decoded index hits a given register
    function automatic logic hit(input logic [8:0] i, input logic [7:0] idx);
        return i == {1'b0, idx};
    endfunction

    // True when the selector holds a given window mode; any other value leaves the pair inert
    function automatic logic in_mode(input logic [7:0] sel, input logic [7:0] m);
        return sel == m;
    endfunction

    logic [8:0]             acc_index;
    logic                   wr_ack;
    logic                   rd_take;
    logic [7:0]             wr_byte;
    logic                   wr_first;
    logic                   wr_second;
    logic [7:0]             loop_current;
    logic [7:0]             next_rdata;

    // Decoded window meaning and request qualifiers
    logic                   mode_address;
    logic                   mode_word;
    logic                   mode_views;
    logic                   req_one;
    logic                   wr_pair;

    // A write lands only at the edge where waitrequest is seen low
    assign acc_index = reg_index(address);
    assign wr_ack    = write && !read && !waitrequest && byteenable[0];
    assign rd_take   = read && !write && waitrequest;
    assign wr_byte   = writedata[7:0];
    assign wr_first  = wr_ack && hit(acc_index, IDX_SHARED_FIRST);
    assign wr_second = wr_ack && hit(acc_index, IDX_SHARED_SECOND);
    assign wr_pair   = wr_first || wr_second;
    // A request with both strobes up is illegal and is left unanswered
    assign req_one   = read ^ write;

    // Decoded once so every latch and the read mux agree on the current window meaning
    assign mode_address = in_mode(window_mode_reg, MODE_ADDRESS); // RULE1
    assign mode_word    = in_mode(window_mode_reg, MODE_WORD); // RULE1
    assign mode_views   = in_mode(window_mode_reg, MODE_VIEWS); // RULE1

    // Bus handshake: one wait cycle, then waitrequest low for exactly one cycle.
    // The gap cycle after each answer keeps a held request from being taken twice.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            waitrequest <= 1'b1;
        end
        else if (req_one && waitrequest)
        begin
            waitrequest <= 1'b0;
        end
        else
        begin
            waitrequest <= 1'b1;
        end
    end

    // Window mode selector, fully readable and writable
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            window_mode_reg <= RST_WINDOW_MODE;
        end
        else if (wr_ack && hit(acc_index, IDX_WINDOW_MODE))
        begin
            window_mode_reg <= wr_byte;
        end
    end

    // Processor address bytes; only mode zero touches them
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            proc_out.address <= {RST_PROC_BYTE, RST_PROC_BYTE};
        end
        else if (mode_address) // RULE1
        begin
            if (wr_first)
            begin
                proc_out.address[7:0] <= wr_byte; // RULE3
            end
            if (wr_second)
            begin
                proc_out.address[15:8] <= wr_byte; // RULE2
            end
        end
        // Other modes leave the latched address alone RULE9
    end

    // Processor data word; the upper byte keeps only six bits
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            proc_out.word <= {RST_PROC_BYTE[WORD_HIGH_W-1:0], RST_PROC_BYTE};
        end
        else if (mode_word) // RULE1
        begin
            if (wr_first)
            begin
                proc_out.word[7:0] <= wr_byte; // RULE4
            end
            if (wr_second)
            begin
                proc_out.word[WORD_W-1:8] <= wr_byte[WORD_HIGH_W-1:0]; // RULE5
            end
        end
        // Bytes survive a mode change untouched RULE9
    end

    // Control view A: write-only, and separate from the status view read at the same location
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            proc_out.control_a <= RST_PROC_BYTE;
        end
        else if (mode_views && wr_first) // RULE1
        begin
            proc_out.control_a <= wr_byte; // RULE7
        end
    end

    // Control view B: behind the second location, which never reads back
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            proc_out.control_b <= RST_PROC_BYTE;
        end
        else if (mode_views && wr_second) // RULE1
        begin
            proc_out.control_b <= wr_byte; // RULE7
        end
    end

    // Address and word strobes pulse on either byte of their pair, so no write order is forced
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            proc_load.address <= 1'b0;
            proc_load.word    <= 1'b0;
        end
        else
        begin
            proc_load.address <= wr_pair && mode_address;
            proc_load.word    <= wr_pair && mode_word;
        end
    end

    // View strobes are one per location, since the two control views are unrelated
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            proc_load.control_a <= 1'b0;
            proc_load.control_b <= 1'b0;
        end
        else
        begin
            proc_load.control_a <= wr_first && mode_views;
            proc_load.control_b <= wr_second && mode_views;
        end
    end

    // Loop current is sampled every cycle; software cannot write it
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            loop_current <= RST_LOOP_CURR; // RULE8
        end
        else
        begin
            loop_current <= loop_current_in; // RULE8
        end
    end

    // Ring-validation and line-interface configuration bytes
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            line_cfg.line_detect <= RST_LINE_DETECT;
            line_cfg.ring_val_1  <= RST_RING_VAL_1;
            line_cfg.ring_val_2  <= RST_RING_VAL_2;
            line_cfg.ring_val_3  <= RST_RING_VAL_3;
            line_cfg.line_cfg_0  <= RST_LINE_CFG_0;
            line_cfg.line_cfg_1  <= RST_LINE_CFG_1;
            line_cfg.line_cfg_2  <= RST_LINE_CFG_2;
            line_cfg.line_cfg_4  <= RST_LINE_CFG_4;
            line_cfg.line_cfg_5  <= RST_LINE_CFG_5;
            line_cfg.line_cfg_6  <= RST_LINE_CFG_6;
            line_cfg.line_cfg_7  <= RST_LINE_CFG_7;
            line_cfg.line_cfg_8  <= RST_LINE_CFG_8;
            line_cfg.line_cfg_9  <= RST_LINE_CFG_9;
        end
        else if (wr_ack)
        begin
            if (hit(acc_index, IDX_LINE_DETECT))
            begin
                line_cfg.line_detect <= wr_byte;
            end
            if (hit(acc_index, IDX_RING_VAL_1))
            begin
                line_cfg.ring_val_1 <= wr_byte;
            end
            if (hit(acc_index, IDX_RING_VAL_2))
            begin
                line_cfg.ring_val_2 <= wr_byte;
            end
            if (hit(acc_index, IDX_RING_VAL_3))
            begin
                line_cfg.ring_val_3 <= wr_byte;
            end
            if (hit(acc_index, IDX_LINE_CFG_0))
            begin
                line_cfg.line_cfg_0 <= wr_byte;
            end
            if (hit(acc_index, IDX_LINE_CFG_1))
            begin
                line_cfg.line_cfg_1 <= wr_byte;
            end
            if (hit(acc_index, IDX_LINE_CFG_2))
            begin
                line_cfg.line_cfg_2 <= wr_byte;
            end
            if (hit(acc_index, IDX_LINE_CFG_4))
            begin
                line_cfg.line_cfg_4 <= wr_byte;
            end
            if (hit(acc_index, IDX_LINE_CFG_5))
            begin
                line_cfg.line_cfg_5 <= wr_byte;
            end
            if (hit(acc_index, IDX_LINE_CFG_6))
            begin
                line_cfg.line_cfg_6 <= wr_byte;
            end
            if (hit(acc_index, IDX_LINE_CFG_7))
            begin
                line_cfg.line_cfg_7 <= wr_byte;
            end
            if (hit(acc_index, IDX_LINE_CFG_8))
            begin
                line_cfg.line_cfg_8 <= wr_byte;
            end
            if (hit(acc_index, IDX_LINE_CFG_9))
            begin
                line_cfg.line_cfg_9 <= wr_byte;
            end
        end
    end

    // Read mux; write-only views, unused modes and unmapped addresses read zero
    always_comb
    begin
        next_rdata = 8'h00;
        if (acc_index[8] == 1'b0)
        begin
            case (acc_index[7:0])
                IDX_SHARED_FIRST:
                begin
                    if (mode_views)
                    begin
                        next_rdata = proc_status_view; // RULE6
                    end
                end
                IDX_WINDOW_MODE:  next_rdata = window_mode_reg;
                IDX_LINE_DETECT:  next_rdata = line_cfg.line_detect;
                IDX_RING_VAL_1:   next_rdata = line_cfg.ring_val_1;
                IDX_RING_VAL_2:   next_rdata = line_cfg.ring_val_2;
                IDX_RING_VAL_3:   next_rdata = line_cfg.ring_val_3;
                IDX_LINE_CFG_0:   next_rdata = line_cfg.line_cfg_0;
                IDX_LINE_CFG_1:   next_rdata = line_cfg.line_cfg_1;
                IDX_LINE_CFG_2:   next_rdata = line_cfg.line_cfg_2;
                IDX_LOOP_CURRENT: next_rdata = loop_current; // RULE8
                IDX_LINE_CFG_4:   next_rdata = line_cfg.line_cfg_4;
                IDX_LINE_CFG_5:   next_rdata = line_cfg.line_cfg_5;
                IDX_LINE_CFG_6:   next_rdata = line_cfg.line_cfg_6;
                IDX_LINE_CFG_7:   next_rdata = line_cfg.line_cfg_7;
                IDX_LINE_CFG_8:   next_rdata = line_cfg.line_cfg_8;
                IDX_LINE_CFG_9:   next_rdata = line_cfg.line_cfg_9;
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    // Read data is captured in the wait cycle so it stands while waitrequest is low
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            readdata <= '0;
        end
        else if (rd_take)
        begin
            readdata <= {{(BUS_DATA_W-8){1'b0}}, next_rdata};
        end
    end

endmodule // idsp_regs

// ### idsp_pkg.sv
// Functional notes
// (RULE1) The value in the window mode selector picks which meaning the two shared locations take.
// (RULE2) In mode zero a write to the second shared location loads processor address bits 15 to 8.
// (RULE3) In mode zero a write to the first shared location loads processor address bits 7 to 0.
// (RULE4) In mode one a write to the first shared location loads processor data word bits 7 to 0.
// (RULE5) In mode one a write to the second shared location loads data word bits 13 to 8, fourteen bits in all.
// (RULE6) In mode two a read of the first shared location returns the processor status view, which is read only.
// (RULE7) In mode two writes to the first and second shared locations update two separate write-only control views.
// (RULE8) Loop current reads back as an unsigned eight-bit count of 1.1 mA steps, zero after reset, and is read only.
// (RULE9) Latched processor address and data bytes stay as they are across mode changes until written again.
package idsp_pkg;

    // Bus geometry: each byte register sits in the low lane of one 32-bit word
    localparam int          BUS_ADDR_W = 10;
    localparam int          BUS_DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_SHARED_FIRST  = 8'he5;
    localparam logic [7:0]  IDX_SHARED_SECOND = 8'he6;
    localparam logic [7:0]  IDX_WINDOW_MODE   = 8'he8;
    localparam logic [7:0]  IDX_LINE_DETECT   = 8'heb;
    localparam logic [7:0]  IDX_RING_VAL_1    = 8'hec;
    localparam logic [7:0]  IDX_RING_VAL_2    = 8'hed;
    localparam logic [7:0]  IDX_RING_VAL_3    = 8'hee;
    localparam logic [7:0]  IDX_LINE_CFG_0    = 8'hf0;
    localparam logic [7:0]  IDX_LINE_CFG_1    = 8'hf1;
    localparam logic [7:0]  IDX_LINE_CFG_2    = 8'hf2;
    localparam logic [7:0]  IDX_LOOP_CURRENT  = 8'hf3;
    localparam logic [7:0]  IDX_LINE_CFG_4    = 8'hf4;
    localparam logic [7:0]  IDX_LINE_CFG_5    = 8'hf5;
    localparam logic [7:0]  IDX_LINE_CFG_6    = 8'hf6;
    localparam logic [7:0]  IDX_LINE_CFG_7    = 8'hf7;
    localparam logic [7:0]  IDX_LINE_CFG_8    = 8'hf8;
    localparam logic [7:0]  IDX_LINE_CFG_9    = 8'hf9;

    // Window modes
    localparam logic [7:0]  MODE_ADDRESS = 8'h00;
    localparam logic [7:0]  MODE_WORD    = 8'h01;
    localparam logic [7:0]  MODE_VIEWS   = 8'h02;

    // Reset values
    localparam logic [7:0]  RST_WINDOW_MODE = 8'h00;
    localparam logic [7:0]  RST_LINE_DETECT = 8'h00;
    localparam logic [7:0]  RST_RING_VAL_1  = 8'h88;
    localparam logic [7:0]  RST_RING_VAL_2  = 8'h19;
    localparam logic [7:0]  RST_RING_VAL_3  = 8'h16;
    localparam logic [7:0]  RST_LINE_CFG_0  = 8'h40;
    localparam logic [7:0]  RST_LINE_CFG_1  = 8'h0c;
    localparam logic [7:0]  RST_LINE_CFG_2  = 8'h00;
    localparam logic [7:0]  RST_LOOP_CURR   = 8'h00;
    localparam logic [7:0]  RST_LINE_CFG_4  = 8'h0f;
    localparam logic [7:0]  RST_LINE_CFG_5  = 8'h00;
    localparam logic [7:0]  RST_LINE_CFG_6  = 8'hf0;
    localparam logic [7:0]  RST_LINE_CFG_7  = 8'h00;
    localparam logic [7:0]  RST_LINE_CFG_8  = 8'h00;
    localparam logic [7:0]  RST_LINE_CFG_9  = 8'h20;
    localparam logic [7:0]  RST_PROC_BYTE   = 8'h00;

    // Field split of the processor data word
    localparam int          WORD_HIGH_W = 6;
    localparam int          WORD_W      = 14;

    // Latched values handed to the signal processor
    typedef struct packed {
        logic [15:0]        address;
        logic [WORD_W-1:0]  word;
        logic [7:0]         control_a;
        logic [7:0]         control_b;
    } idsp_proc_t;

    // One-cycle load strobes that go with idsp_proc_t
    typedef struct packed {
        logic               address;
        logic               word;
        logic               control_a;
        logic               control_b;
    } idsp_load_t;

    // Ring-validation and line-interface configuration
    typedef struct packed {
        logic [7:0]         line_detect;
        logic [7:0]         ring_val_1;
        logic [7:0]         ring_val_2;
        logic [7:0]         ring_val_3;
        logic [7:0]         line_cfg_0;
        logic [7:0]         line_cfg_1;
        logic [7:0]         line_cfg_2;
        logic [7:0]         line_cfg_4;
        logic [7:0]         line_cfg_5;
        logic [7:0]         line_cfg_6;
        logic [7:0]         line_cfg_7;
        logic [7:0]         line_cfg_8;
        logic [7:0]         line_cfg_9;
    } idsp_cfg_t;

endpackage

// ### idsp_regs_assertions.sv
`timescale 1ns/100ps

module idsp_regs_chk
    import idsp_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire logic [BUS_ADDR_W-1:0] address,
    input wire logic                  read,
    input wire logic                  write,
    input wire logic [BUS_DATA_W-1:0] writedata,
    input wire logic [3:0]            byteenable,
    input wire logic [BUS_DATA_W-1:0] readdata,
    input wire logic                  waitrequest,
    input wire logic [7:0]            proc_status_view,
    input idsp_proc_t                 proc_out,
    input idsp_load_t                 proc_load,
    input wire logic [7:0]            window_mode_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Completed aligned accesses; a write only counts with the low lane enabled
    logic [7:0] idx;
    logic       wr_ok;
    logic       rd_ok;
    assign idx   = address[9:2];
    assign wr_ok = write && !read && !waitrequest && byteenable[0] && address[1:0] == 2'b00;
    assign rd_ok = read && !write && !waitrequest && address[1:0] == 2'b00;

    property p_mode_load;
        wr_ok && idx == IDX_WINDOW_MODE |=> window_mode_reg == $past(writedata[7:0]);
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("window mode not loaded");
    property p_addr_high;
        wr_ok && idx == IDX_SHARED_SECOND && window_mode_reg == MODE_ADDRESS
            |=> proc_out.address[15:8] == $past(writedata[7:0]) && proc_load.address;
    endproperty
    a_addr_high: assert property (p_addr_high) else $error("address high byte wrong");
    property p_addr_low;
        wr_ok && idx == IDX_SHARED_FIRST && window_mode_reg == MODE_ADDRESS
            |=> proc_out.address[7:0] == $past(writedata[7:0]) && proc_load.address;
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("address low byte wrong");
    property p_word_low;
        wr_ok && idx == IDX_SHARED_FIRST && window_mode_reg == MODE_WORD
            |=> proc_out.word[7:0] == $past(writedata[7:0]) && proc_load.word;
    endproperty
    a_word_low: assert property (p_word_low) else $error("word low byte wrong");
    property p_word_high;
        wr_ok && idx == IDX_SHARED_SECOND && window_mode_reg == MODE_WORD
            |=> proc_out.word[13:8] == $past(writedata[5:0]) && proc_load.word;
    endproperty
    a_word_high: assert property (p_word_high) else $error("word high bits wrong");
    property p_status;
        rd_ok && idx == IDX_SHARED_FIRST && window_mode_reg == MODE_VIEWS
            |-> readdata == {24'h0, $past(proc_status_view)};
    endproperty
    a_status: assert property (p_status) else $error("status view read wrong");
    property p_ctrl_a;
        wr_ok && idx == IDX_SHARED_FIRST && window_mode_reg == MODE_VIEWS
            |=> proc_out.control_a == $past(writedata[7:0]) && proc_load.control_a;
    endproperty
    a_ctrl_a: assert property (p_ctrl_a) else $error("control view a wrong");
    property p_ctrl_b;
        wr_ok && idx == IDX_SHARED_SECOND && window_mode_reg == MODE_VIEWS
            |=> proc_out.control_b == $past(writedata[7:0]) && proc_load.control_b;
    endproperty
    a_ctrl_b: assert property (p_ctrl_b) else $error("control view b wrong");
    // Latched bytes may only move together with a load pulse, never on a mode change
    property p_keep;
        !$stable(proc_out) |-> |proc_load;
    endproperty
    a_keep: assert property (p_keep) else $error("latched bytes moved without load");

    c_status: cover property (rd_ok && idx == IDX_SHARED_FIRST && window_mode_reg == MODE_VIEWS);
    c_inert: cover property (wr_ok && idx == IDX_SHARED_FIRST && window_mode_reg > MODE_VIEWS);
    c_word: cover property (wr_ok && idx == IDX_SHARED_SECOND && window_mode_reg == MODE_WORD);
    c_mode: cover property (wr_ok && idx == IDX_WINDOW_MODE);
endmodule // idsp_regs_chk

bind idsp_regs idsp_regs_chk u_chk (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .address          (address),
    .read             (read),
    .write            (write),
    .writedata        (writedata),
    .byteenable       (byteenable),
    .readdata         (readdata),
    .waitrequest      (waitrequest),
    .proc_status_view (proc_status_view),
    .proc_out         (proc_out),
    .proc_load        (proc_load),
    .window_mode_reg  (window_mode_reg)
);

// ### indirect_dsp_access_regs_bench.sv
`timescale 1ns/100ps

module indirect_dsp_access_regs_bench
    import idsp_pkg::*;
;
    logic                  clk_sys, rst, read, write, waitrequest;
    logic [BUS_ADDR_W-1:0] address;
    logic [BUS_DATA_W-1:0] writedata, readdata;
    logic [3:0]            byteenable;
    logic [7:0]            proc_status_view, loop_current_in, window_mode_reg;
    idsp_proc_t            proc_out, exp_proc;
    idsp_load_t            proc_load;
    idsp_cfg_t             line_cfg;
    logic [31:0]           seed = 32'h38098a55;
    int                    error_cnt = 0;
    int                    checks_done = 0;
    logic [7:0]            rd_q[$];
    idsp_proc_t            proc_q[$];
    // Plain byte registers and their reset values
    logic [7:0] reg_idx[15] = '{8'he8, 8'heb, 8'hec, 8'hed, 8'hee, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5,
                                8'hf6, 8'hf7, 8'hf8, 8'hf9};
    logic [7:0] reg_rst[15] = '{8'h00, 8'h00, 8'h88, 8'h19, 8'h16, 8'h40, 8'h0c, 8'h00, 8'h00, 8'h0f, 8'h00,
                                8'hf0, 8'h00, 8'h00, 8'h20};

    idsp_regs dut (.clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .proc_status_view(proc_status_view), .loop_current_in(loop_current_in), .proc_out(proc_out),
        .proc_load(proc_load), .line_cfg(line_cfg), .window_mode_reg(window_mode_reg));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic give_verdict;
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t read got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_proc(input idsp_proc_t got, input idsp_proc_t exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t proc got %h exp %h", $time, got, exp);
        end
    endtask

    // One transfer; a spare edge first so release and next request never share a step
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [1:0] lo);
        int n;
        @(posedge clk_sys);
        address   <= {idx, lo};
        writedata <= {seed[31:8], d};
        read      <= !wr;
        write     <= wr;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (waitrequest && n < 20);
        if (waitrequest)
        begin
            error_cnt++;
            give_verdict();
        end
        else
        begin
            read  <= 1'b0;
            write <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [1:0] lo, input logic [7:0] exp);
        rd_q.push_back(exp);
        xfer(1'b0, idx, 8'h00, lo);
    endtask

    // Shared location write; the model follows the current mode
    task automatic wr_shared(input logic [7:0] idx, input logic [7:0] d, input int m);
        case (m)
            0: if (idx == IDX_SHARED_FIRST) exp_proc.address[7:0] = d; else exp_proc.address[15:8] = d;
            1: if (idx == IDX_SHARED_FIRST) exp_proc.word[7:0] = d; else exp_proc.word[13:8] = d[5:0];
            2: if (idx == IDX_SHARED_FIRST) exp_proc.control_a = d; else exp_proc.control_b = d;
            default: ;
        endcase
        if (m < 3)
            proc_q.push_back(exp_proc);
        xfer(1'b1, idx, d, 2'b00);
    endtask

    // Results are matched against the oldest note when they appear
    always @(posedge clk_sys)
    begin
        if (!rst && read && !waitrequest)
            cmp_rd(readdata, rd_q.size() > 0 ? {24'h0, rd_q.pop_front()} : 'x);
        if (!rst && proc_load !== 4'h0)
            cmp_proc(proc_out, proc_q.size() > 0 ? proc_q.pop_front() : 'x);
    end

    initial
    begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        byteenable = 4'he;
        proc_status_view = 8'h00;
        loop_current_in = 8'h00;
        exp_proc = '0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        // Disabled low lane must leave the register alone
        xfer(1'b1, IDX_LINE_CFG_0, 8'h00, 2'b00);
        byteenable <= 4'hf;
        foreach (reg_idx[i])
            rd(reg_idx[i], 2'b00, reg_rst[i]);
        seed = lfsr(seed);
        loop_current_in <= seed[7:0];
        // Storage readback; loop current ignores writes and follows its input
        foreach (reg_idx[i])
        begin
            seed = lfsr(seed);
            xfer(1'b1, reg_idx[i], seed[7:0], 2'b00);
            rd(reg_idx[i], 2'b00, reg_idx[i] == IDX_LOOP_CURRENT ? loop_current_in : seed[7:0]);
        end
        rd(8'he7, 2'b00, 8'h00);
        rd(IDX_WINDOW_MODE, 2'b01, 8'h00);
        // Mode 3 is inert, so earlier latched values must survive it
        repeat (2)
            for (int m = 0; m < 4; m++)
            begin
                xfer(1'b1, IDX_WINDOW_MODE, m[7:0], 2'b00);
                seed = lfsr(seed);
                proc_status_view <= seed[15:8];
                wr_shared(IDX_SHARED_FIRST, seed[7:0], m);
                wr_shared(IDX_SHARED_SECOND, seed[23:16], m);
                rd(IDX_SHARED_FIRST, 2'b00, m == 2 ? proc_status_view : 8'h00);
                rd(IDX_SHARED_SECOND, 2'b00, 8'h00);
                rd(IDX_WINDOW_MODE, 2'b00, m[7:0]);
            end
        repeat (4) @(posedge clk_sys);
        cmp_rd(32'(rd_q.size() + proc_q.size()), 32'h0);
        give_verdict();
    end
endmodule // indirect_dsp_access_regs_bench
